// >>> wdt_pkg.sv
// Behaviour
// - edge in closed window is early fault
// - no edge by period end is late fault
// - edge in open window is good strobe
// - three consecutive faults assert failover
// - three consecutive good strobes release failover
// - counter clears on reset release, good edge
// - counter held zero while reset asserted
// - counter starts from zero at release
// - strobe edges ignored while reset asserted
// - open window 50 or 75 percent
// - zero watchdog setting disables watchdog entirely
// - reset held during undervoltage plus timeout
// - fault gives reset for exactly timeout
// - period is closed plus open window
// - failover never asserted during undervoltage
package wdt_pkg;
  localparam int unsigned CNT_W = 24;
  localparam int unsigned FAULT_LIMIT = 3;
  localparam int unsigned GOOD_LIMIT = 3;
  localparam int unsigned OPEN_PCT_HALF = 50;
  localparam int unsigned OPEN_PCT_3Q = 75;
  localparam logic [1:0] STREAK_ZERO = 2'h0;
  typedef enum logic [1:0] {ST_HOLD, ST_RUN} rst_state_e;
endpackage

// >>> window_watchdog_failover.sv
`timescale 1ns/1ps
module window_watchdog_failover
  import wdt_pkg::*;
#(
  parameter int unsigned OPEN_PCT = OPEN_PCT_3Q
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // timing settings, in sys_clk cycles
  input wire logic [CNT_W-1:0] watchdog_timing_setting_in,
  input wire logic [CNT_W-1:0] reset_timing_setting_in,
  // monitored inputs
  input wire logic monitored_voltage_input_in,
  input wire logic watchdog_strobe_input_in,
  // outputs
  output logic reset_n_out,
  output logic failover_n_out
);
  if (OPEN_PCT != OPEN_PCT_HALF && OPEN_PCT != OPEN_PCT_3Q) begin : g_bad_open
    $error("OPEN_PCT must be 50 or 75");
  end

  logic sync1_q, sync2_q, sync3_q;
  logic [CNT_W-1:0] wd_cnt_q;
  logic [CNT_W-1:0] rst_cnt_q;
  logic [CNT_W-1:0] closed_len;
  logic [CNT_W+7:0] closed_wide;
  logic fall_edge, wd_on, early_fault, late_fault, good_edge, fault;
  logic [1:0] bad_streak_q, good_streak_q;
  rst_state_e state_q;

  // three flops then edge detect on the second and third only
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      sync3_q <= 1'b1;
    end else begin
      sync1_q <= watchdog_strobe_input_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end
  assign fall_edge = sync3_q && !sync2_q;

  // closed part is the remainder of the period
  assign closed_wide = 32'(watchdog_timing_setting_in) * 32'(100 - OPEN_PCT) / 32'h64;
  assign closed_len = closed_wide[CNT_W-1:0];
  assign wd_on = (watchdog_timing_setting_in != '0) && monitored_voltage_input_in;
  assign early_fault = wd_on && reset_n_out && fall_edge && (wd_cnt_q < closed_len);
  assign good_edge = wd_on && reset_n_out && fall_edge && (wd_cnt_q >= closed_len);
  assign late_fault = wd_on && reset_n_out && !fall_edge
                      && (wd_cnt_q >= watchdog_timing_setting_in - 1'b1);
  assign fault = early_fault || late_fault;

  // watchdog counter
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wd_cnt_q <= '0;
    end else if (!reset_n_out || !wd_on || fault || good_edge) begin
      wd_cnt_q <= '0;
    end else begin
      wd_cnt_q <= wd_cnt_q + 1'b1;
    end
  end

  // reset output sequencer; undervoltage restarts the timeout
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= ST_HOLD;
      rst_cnt_q <= '0;
      reset_n_out <= 1'b0;
    end else begin
      unique case (state_q)
        ST_HOLD: begin
          if (!monitored_voltage_input_in) begin
            rst_cnt_q <= '0;
          end else if (rst_cnt_q + 1'b1 >= reset_timing_setting_in) begin
            state_q <= ST_RUN;
            reset_n_out <= 1'b1;
          end else begin
            rst_cnt_q <= rst_cnt_q + 1'b1;
          end
        end
        ST_RUN: begin
          if (!monitored_voltage_input_in || fault) begin
            state_q <= ST_HOLD;
            rst_cnt_q <= '0;
            reset_n_out <= 1'b0;
          end
        end
        default: begin
          state_q <= ST_HOLD;
          reset_n_out <= 1'b0;
        end
      endcase
    end
  end

  // streak counters; a good strobe breaks a fault streak and vice versa
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bad_streak_q <= STREAK_ZERO;
      good_streak_q <= STREAK_ZERO;
      failover_n_out <= 1'b1;
    end else if (!monitored_voltage_input_in) begin
      bad_streak_q <= STREAK_ZERO;
      good_streak_q <= STREAK_ZERO;
      failover_n_out <= 1'b1;
    end else if (fault) begin
      good_streak_q <= STREAK_ZERO;
      if (bad_streak_q + 1'b1 >= 2'(FAULT_LIMIT)) begin
        failover_n_out <= 1'b0;
        bad_streak_q <= STREAK_ZERO;
      end else begin
        bad_streak_q <= bad_streak_q + 1'b1;
      end
    end else if (good_edge) begin
      bad_streak_q <= STREAK_ZERO;
      if (good_streak_q + 1'b1 >= 2'(GOOD_LIMIT)) begin
        failover_n_out <= 1'b1;
        good_streak_q <= STREAK_ZERO;
      end else begin
        good_streak_q <= good_streak_q + 1'b1;
      end
    end
  end

  // checker helpers: length of the current reset pulse
  logic [CNT_W-1:0] low_len_q;
  logic uv_seen_q;
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      low_len_q <= '0;
    end else if (reset_n_out) begin
      low_len_q <= '0;
    end else begin
      low_len_q <= low_len_q + 1'b1;
    end
  end

  // power-on pulse and pulses touched by undervoltage have no fixed length
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      uv_seen_q <= 1'b1;
    end else if (reset_n_out) begin
      uv_seen_q <= !monitored_voltage_input_in;
    end else if (!monitored_voltage_input_in) begin
      uv_seen_q <= 1'b1;
    end
  end

  a_hold_zero: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    !reset_n_out |=> wd_cnt_q == '0)
    else $error("counter moved in reset");
  a_fault_reset: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    fault && monitored_voltage_input_in |=> !reset_n_out)
    else $error("fault missed");
  a_reset_len: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    $rose(reset_n_out) && !uv_seen_q |->
      low_len_q == ((reset_timing_setting_in > CNT_W'(1)) ? reset_timing_setting_in : CNT_W'(1)))
    else $error("reset pulse length wrong");
  a_uv_reset: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    !monitored_voltage_input_in |=> !reset_n_out)
    else $error("reset high in uv");
  a_uv_failover: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    !monitored_voltage_input_in |=> failover_n_out)
    else $error("failover in uv");
  a_ignore_low: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    !reset_n_out |-> !good_edge && !fault)
    else $error("edge seen in reset");
  a_disabled: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    watchdog_timing_setting_in == '0 |-> !fault)
    else $error("fault while off");
  a_disable_cnt: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    !wd_on |=> wd_cnt_q == '0)
    else $error("counter runs while off");
  a_early_reset: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    wd_on && reset_n_out && fall_edge && wd_cnt_q < closed_len |=> !reset_n_out)
    else $error("early edge kept reset high");
  a_late_fault: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    wd_on && reset_n_out && !fall_edge
      && wd_cnt_q == watchdog_timing_setting_in - CNT_W'(1) |=> !reset_n_out)
    else $error("late fault missed");
  a_good_keep: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    good_edge && monitored_voltage_input_in |=> reset_n_out)
    else $error("good strobe gave reset");
  a_restart: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    $rose(reset_n_out) |-> wd_cnt_q == '0)
    else $error("no restart");
  a_good_clear: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    good_edge |=> wd_cnt_q == '0)
    else $error("counter not cleared");
  a_count_step: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    reset_n_out && wd_on && !fault && !good_edge |=> wd_cnt_q == $past(wd_cnt_q) + CNT_W'(1))
    else $error("counter did not step");
  a_cnt_bound: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    reset_n_out && wd_on |-> wd_cnt_q < watchdog_timing_setting_in)
    else $error("counter past period");
  a_window_split: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    wd_on |-> 40'(closed_len) * 40'h64 <= 40'(watchdog_timing_setting_in) * 40'(100 - OPEN_PCT)
      && 40'(watchdog_timing_setting_in) * 40'(100 - OPEN_PCT)
      < (40'(closed_len) + 40'h1) * 40'h64)
    else $error("closed window size wrong");
  a_fail_set: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    fault && bad_streak_q == 2'(FAULT_LIMIT - 1) |=> !failover_n_out)
    else $error("failover not set");
  a_fail_cause: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    $fell(failover_n_out) |-> $past(fault))
    else $error("failover without fault");
  a_fail_rel: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    good_edge && good_streak_q == 2'(GOOD_LIMIT - 1) |=> failover_n_out)
    else $error("failover not released");
  a_rel_cause: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    $rose(failover_n_out) |-> $past(good_edge) || !$past(monitored_voltage_input_in))
    else $error("failover released early");
  a_no_repeat: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    fault |=> !fault)
    else $error("fault twice in a row");

  c_fault: cover property (@(posedge sys_clk_in) early_fault);
  c_good: cover property (@(posedge sys_clk_in) good_edge);
  c_late: cover property (@(posedge sys_clk_in) late_fault);
  c_fail: cover property (@(posedge sys_clk_in) $fell(failover_n_out));
  c_recover: cover property (@(posedge sys_clk_in) $rose(failover_n_out));
endmodule // window_watchdog_failover

// >>> uc_model.sv
`timescale 1ns/1ps
module uc_model (
  // clock and device reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // strobe timing, cycles after release or last strobe
  input wire logic [7:0] gap_in,
  // strobe pin and end-of-period marker
  output logic strobe_out = 1'b1,
  output logic done_out = 1'b0
);
  logic [7:0] cnt_q = 8'h0;
  // restart at 3: device zeroed its counter three edges back
  always @(posedge clk_in) begin
    done_out <= (cnt_q == gap_in + 9'h6);
    if (!reset_n_in) begin
      cnt_q <= 8'h0;
      strobe_out <= 1'b1;
    end else begin
      cnt_q <= (cnt_q == gap_in + 9'h6) ? 8'h3 : cnt_q + 8'h1;
      strobe_out <= !(cnt_q >= gap_in && cnt_q < gap_in + 9'h2);
    end
  end
endmodule // uc_model

// >>> test_window_watchdog_failover.sv
`timescale 1ns/1ps
module test_window_watchdog_failover;
  import wdt_pkg::*;
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [CNT_W-1:0] wd_set = 24'h14;
  logic volt_ok = 1'b0;
  logic [7:0] gap = 8'hff;
  logic strobe, done, reset_n_out, failover_n_out;
  int err_total = 0;
  int check_count = 0;
  int len;
  int low_len = 0;
  localparam logic [CNT_W-1:0] RST_SET = 24'h5;
  localparam int UV_LEN = 3;
  logic [9:0] exp_q[$];
  always #50 sys_clk_in = !sys_clk_in;
  window_watchdog_failover u_window_watchdog_failover (.sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in), .watchdog_timing_setting_in(wd_set),
    .reset_timing_setting_in(RST_SET), .monitored_voltage_input_in(volt_ok),
    .watchdog_strobe_input_in(strobe), .reset_n_out(reset_n_out),
    .failover_n_out(failover_n_out));
  uc_model u_uc_model (.clk_in(sys_clk_in), .reset_n_in(reset_n_out), .gap_in(gap),
    .strobe_out(strobe), .done_out(done));
  task automatic check(input logic [9:0] seen, input logic [9:0] want);
    check_count++;
    if (seen !== want) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // one result: note reset pulse, failover level and pulse length; bounded wait
  task automatic step(input logic [7:0] g, input logic flt, input logic fo, input int n_low);
    int n;
    gap <= g;
    exp_q.push_back({flt, fo, 8'(n_low)});
    for (n = 0; n < 80 && exp_q.size() != 0; n++) @(posedge sys_clk_in);
    if (n == 80) begin
      err_total++;
      summarize();
    end
  endtask
  // watcher: end of a reset pulse or the partner's period marker closes a result
  always @(negedge sys_clk_in) begin
    logic [9:0] seen_v;
    seen_v = {low_len != 0, failover_n_out, 8'(low_len)};
    if (rst_n_in && reset_n_out === 1'b0) begin
      low_len++;
    end else if (rst_n_in && (low_len != 0 || (done === 1'b1 && wd_set != '0))) begin
      if (exp_q.size() == 0) exp_q.push_back(~seen_v);
      check(seen_v, exp_q.pop_front());
      low_len = 0;
    end
  end
  initial begin
    void'($urandom(32'ha4a15179));
    repeat (8) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    volt_ok <= 1'b1;
    step(8'hff, 1'b1, 1'b1, RST_SET);
    step(8'h9 + 8'($urandom % 7), 1'b0, 1'b1, 0);
    step(8'hff, 1'b1, 1'b1, RST_SET);
    step(8'h1, 1'b1, 1'b1, RST_SET);
    step(8'h1, 1'b1, 1'b0, RST_SET);
    for (int i = 0; i < 3; i++) step(8'h9 + 8'($urandom % 7), 1'b0, i == 2, 0);
    $display("test fault streaks done");
    volt_ok <= 1'b0;
    repeat (UV_LEN - 1) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    check({8'h0, reset_n_out, failover_n_out}, 10'h1);
    @(posedge sys_clk_in);
    volt_ok <= 1'b1;
    wd_set <= 24'h0;
    // reset falls one cycle after the drop, on the edge that sees it, then a full timeout
    step(8'h1, 1'b1, 1'b1, UV_LEN + RST_SET - 1);
    len = 0;
    repeat (60) @(negedge sys_clk_in) len += (reset_n_out !== 1'b1);
    check(10'(len), 10'h0);
    $display("test voltage and disable done");
    summarize();
  end
endmodule // test_window_watchdog_failover
